// ### occ_pkg.sv
// Constants and types shared by the oscillator clock switch
`default_nettype none

package occ_pkg;

    ////////////////////////////////////////////////////////////
    // System clock
    ////////////////////////////////////////////////////////////

    // Rate of clk_i in kHz
    localparam longint OCC_CLK_KHZ = 125000;
    // Width of the internal oscillator phase accumulator
    localparam int OCC_ACC_W = 24;

    ////////////////////////////////////////////////////////////
    // Internal oscillator nominal frequencies in kHz
    ////////////////////////////////////////////////////////////

    localparam longint OCC_F4M0_KHZ = 4000;
    localparam longint OCC_F8M0_KHZ = 8000;
    localparam longint OCC_F12M8_KHZ = 12800;
    localparam longint OCC_F25M6_KHZ = 25600;

    // Phase steps per clk_i cycle, derived from the rates
    localparam logic [23:0] OCC_INC_4M0 =
        24'((OCC_F4M0_KHZ << OCC_ACC_W) / OCC_CLK_KHZ);
    localparam logic [23:0] OCC_INC_8M0 =
        24'((OCC_F8M0_KHZ << OCC_ACC_W) / OCC_CLK_KHZ);
    localparam logic [23:0] OCC_INC_12M8 =
        24'((OCC_F12M8_KHZ << OCC_ACC_W) / OCC_CLK_KHZ);
    localparam logic [23:0] OCC_INC_25M6 =
        24'((OCC_F25M6_KHZ << OCC_ACC_W) / OCC_CLK_KHZ);

    // One trim step moves the period by 1/512 of nominal
    localparam int OCC_TRIM_SHIFT = 9;

    ////////////////////////////////////////////////////////////
    // Register map (byte offsets) and field positions
    ////////////////////////////////////////////////////////////

    localparam logic [3:0] OCC_CTRL_OFS = 4'h0;
    localparam logic [3:0] OCC_TRIM_OFS = 4'h4;
    localparam int OCC_SRC_LSB = 0;
    localparam int OCC_FREQ_LSB = 2;
    localparam int OCC_RANGE_LSB = 4;
    localparam int OCC_REQ_BIT = 6;
    localparam int OCC_ENG_BIT = 7;
    localparam int OCC_OUTEN_BIT = 8;
    localparam int OCC_KEEP_BIT = 9;

    // Source select encodings
    localparam logic [1:0] OCC_SRC_INT = 2'h0;
    localparam logic [1:0] OCC_SRC_EXT = 2'h1;
    localparam logic [1:0] OCC_SRC_RC = 2'h2;
    localparam logic [1:0] OCC_SRC_XTAL = 2'h3;

    // Internal frequency encodings
    localparam logic [1:0] OCC_FREQ_4M0 = 2'h0;
    localparam logic [1:0] OCC_FREQ_8M0 = 2'h1;
    localparam logic [1:0] OCC_FREQ_12M8 = 2'h2;
    localparam logic [1:0] OCC_FREQ_25M6 = 2'h3;

    // Reset values
    localparam logic [7:0] OCC_TRIM_RST = 8'h00;
    localparam logic [1:0] OCC_RANGE_RST = 2'h0;

    // Rising edges of an external source before engaging
    localparam logic [1:0] OCC_CONFIRM_EDGES = 2'h2;

    // Software-writable control fields
    typedef struct packed {
        logic keep_running_in_stop;
        logic clock_out_pin_enable;
        logic external_clock_request;
        logic [1:0] crystal_range_select;
        logic [1:0] internal_freq_select;
        logic [1:0] source_select;
    } occ_ctrl_t;

endpackage : occ_pkg

`default_nettype wire

// ### occ_nco.sv
// Trimmable internal oscillator modelled as a phase accumulator
`default_nettype none

module occ_nco #(
    parameter int ACC_W = 24
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [1:0] freq_i,
    input wire logic [7:0] trim_i,
    output logic osc_o
);

    // Nominal step, trim product and trimmed step
    logic [23:0] base;
    logic signed [33:0] prod;
    logic [23:0] step;
    logic [ACC_W-1:0] acc_q;

    // Nominal step from the frequency field
    always_comb begin
        case (freq_i)
            occ_pkg::OCC_FREQ_8M0: base = occ_pkg::OCC_INC_8M0;
            occ_pkg::OCC_FREQ_12M8: base = occ_pkg::OCC_INC_12M8;
            occ_pkg::OCC_FREQ_25M6: base = occ_pkg::OCC_INC_25M6;
            default: base = occ_pkg::OCC_INC_4M0;
        endcase
    end

    // Signed trim: higher value, smaller step, longer period
    always_comb begin
        prod = $signed({1'b0, base}) * $signed(trim_i);
        step = base - 24'(prod >>> occ_pkg::OCC_TRIM_SHIFT);
    end

    // Accumulator holds still while the oscillator is stopped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_q <= '0;
        end else if (run_i) begin
            acc_q <= acc_q + ACC_W'(step);
        end
    end

    // Oscillator level is the accumulator top bit
    assign osc_o = acc_q[ACC_W-1];

endmodule : occ_nco

`default_nettype wire

// ### occ_top.sv
// Oscillator source selection, glitch-free switch and clock pins
`default_nettype none

module occ_top (
    input wire logic clk_i,
    input wire logic rst_i,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // External clock sources, sampled levels
    input wire logic clock_in_pin_i,
    input wire logic resistor_cap_clock_i,
    input wire logic crystal_clock_i,
    // Integration unit: low disables sources in stop
    input wire logic stop_source_enable_i,
    // Generated clocks toward the integration unit
    output logic full_rate_clock_o,
    output logic half_rate_clock_o,
    // Pin control
    output logic clock_in_pin_en_o,
    output logic clock_out_pin_o,
    output logic clock_out_pin_oe_o,
    // Internal oscillator running
    output logic internal_osc_run_o
);

    ////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////

    // Switch sequencer states
    typedef enum logic [2:0] {
        OCC_ST_INT,
        OCC_ST_CONFIRM,
        OCC_ST_ENGAGE,
        OCC_ST_EXT,
        OCC_ST_RETURN
    } occ_state_t;

    occ_pkg::occ_ctrl_t ctrl_q; // Writable control fields
    logic [7:0] trim_q; // Trim step count
    logic ack_q; // Bus acknowledge
    logic [31:0] rdat_q; // Bus read data
    occ_state_t state_q; // Sequencer state
    logic engaged_q; // External clock engaged status
    logic sel_ext_q; // Clock mux selects external
    logic int_run_q; // Internal oscillator enabled
    logic [1:0] edge_cnt_q; // Confirmed external edges
    logic ext_q; // Previous external level
    logic full_q; // Full-rate clock
    logic half_q; // Half-rate clock
    logic in_en_q; // Input pin enable
    logic out_q; // Output pin level
    logic oe_q; // Output pin enable
    logic src_run; // Source allowed by stop logic
    logic int_clk; // Internal oscillator level
    logic ext_lvl; // Selected external level
    logic ext_rise; // External rising edge
    logic full_d; // Next full-rate level
    logic bus_req; // New bus request this cycle
    logic wr_ctrl; // Write strobe, control
    logic wr_trim; // Write strobe, trim
    logic leave_req; // Software asked to go back
    logic [1:0] src_d; // Source select after write

    ////////////////////////////////////////////////////////////
    // Wishbone slave
    ////////////////////////////////////////////////////////////

    // One request per handshake; ack drops after one cycle
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_ctrl = bus_req && wb_we_i && wb_adr_i == occ_pkg::OCC_CTRL_OFS;
    assign wr_trim = bus_req && wb_we_i && wb_adr_i == occ_pkg::OCC_TRIM_OFS;

    // Acknowledge one cycle after the request, any address
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    // Read data; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                // Control word with live engaged status
                occ_pkg::OCC_CTRL_OFS: begin
                    rdat_q <= {22'h00_0000,
                        ctrl_q.keep_running_in_stop,
                        ctrl_q.clock_out_pin_enable,
                        engaged_q,
                        ctrl_q.external_clock_request,
                        ctrl_q.crystal_range_select,
                        ctrl_q.internal_freq_select,
                        ctrl_q.source_select};
                end
                // Trim in the low byte
                occ_pkg::OCC_TRIM_OFS: begin
                    rdat_q <= {24'h00_0000, trim_q};
                end
                // Nothing mapped here
                default: begin
                    rdat_q <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    ////////////////////////////////////////////////////////////
    // Control and trim registers
    ////////////////////////////////////////////////////////////

    // Source select as it stands after this cycle's write
    assign src_d = (wr_ctrl && wb_sel_i[0])
        ? wb_dat_i[occ_pkg::OCC_SRC_LSB +: 2] : ctrl_q.source_select;

    // Control fields; reset gives internal at 4.0 MHz
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q.source_select <= occ_pkg::OCC_SRC_INT;
            ctrl_q.internal_freq_select <= occ_pkg::OCC_FREQ_4M0;
            ctrl_q.crystal_range_select <= occ_pkg::OCC_RANGE_RST;
            ctrl_q.external_clock_request <= 1'b0;
            ctrl_q.clock_out_pin_enable <= 1'b0;
            ctrl_q.keep_running_in_stop <= 1'b0;
        end else begin
            // Low byte: select, frequency, range, request
            if (wr_ctrl && wb_sel_i[0]) begin
                ctrl_q.source_select <= src_d;
                ctrl_q.internal_freq_select <=
                    wb_dat_i[occ_pkg::OCC_FREQ_LSB +: 2];
                ctrl_q.crystal_range_select <=
                    wb_dat_i[occ_pkg::OCC_RANGE_LSB +: 2];
                ctrl_q.external_clock_request <=
                    wb_dat_i[occ_pkg::OCC_REQ_BIT];
            end
            // Second byte: output enable and stop option
            if (wr_ctrl && wb_sel_i[1]) begin
                ctrl_q.clock_out_pin_enable <=
                    wb_dat_i[occ_pkg::OCC_OUTEN_BIT];
                ctrl_q.keep_running_in_stop <=
                    wb_dat_i[occ_pkg::OCC_KEEP_BIT];
            end
            // External clock mode holds output enable clear
            if (src_d == occ_pkg::OCC_SRC_EXT) begin
                ctrl_q.clock_out_pin_enable <= 1'b0;
            end
        end
    end

    // Trim starts at zero; only software loads it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trim_q <= occ_pkg::OCC_TRIM_RST;
        end else if (wr_trim && wb_sel_i[0]) begin
            trim_q <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////
    // Sources
    ////////////////////////////////////////////////////////////

    // Stop-mode gating, overridden by keep-running
    assign src_run = stop_source_enable_i
        || ctrl_q.keep_running_in_stop;

    // Internal oscillator with trim applied
    occ_nco #(
        .ACC_W(occ_pkg::OCC_ACC_W)
    ) u_nco (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(int_run_q && src_run),
        .freq_i(ctrl_q.internal_freq_select),
        .trim_i(trim_q),
        .osc_o(int_clk)
    );

    // Chosen external source, silent while stopped
    always_comb begin
        case (ctrl_q.source_select)
            occ_pkg::OCC_SRC_EXT: ext_lvl = clock_in_pin_i;
            occ_pkg::OCC_SRC_RC: ext_lvl = resistor_cap_clock_i;
            occ_pkg::OCC_SRC_XTAL: ext_lvl = crystal_clock_i;
            default: ext_lvl = 1'b0;
        endcase
        if (!src_run) begin
            ext_lvl = 1'b0;
        end
    end

    // Previous external level for edge detection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= ext_lvl;
        end
    end

    assign ext_rise = ext_lvl && !ext_q;
    assign leave_req = ctrl_q.source_select == occ_pkg::OCC_SRC_INT
        && !ctrl_q.external_clock_request;

    ////////////////////////////////////////////////////////////
    // Switch sequencer
    ////////////////////////////////////////////////////////////

    // Confirm, engage while both clocks low, then stop internal
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= OCC_ST_INT;
            engaged_q <= 1'b0;
            sel_ext_q <= 1'b0;
            int_run_q <= 1'b1;
            edge_cnt_q <= 2'h0;
        end else begin
            case (state_q)
                // Running on internal; wait for a request
                OCC_ST_INT: begin
                    edge_cnt_q <= 2'h0;
                    if (ctrl_q.external_clock_request && !leave_req
                        && ctrl_q.source_select != occ_pkg::OCC_SRC_INT) begin
                        state_q <= OCC_ST_CONFIRM;
                    end
                end
                // Count external rising edges
                OCC_ST_CONFIRM: begin
                    if (!ctrl_q.external_clock_request
                        || ctrl_q.source_select == occ_pkg::OCC_SRC_INT) begin
                        state_q <= OCC_ST_INT;
                    end else if (edge_cnt_q == occ_pkg::OCC_CONFIRM_EDGES) begin
                        state_q <= OCC_ST_ENGAGE;
                    end else if (ext_rise) begin
                        edge_cnt_q <= edge_cnt_q + 2'h1;
                    end
                end
                // Swap only while both clocks sit low
                OCC_ST_ENGAGE: begin
                    if (!ext_lvl && !full_q) begin
                        sel_ext_q <= 1'b1;
                        engaged_q <= 1'b1;
                        state_q <= OCC_ST_EXT;
                    end
                end
                // Engaged; internal stops one cycle later
                OCC_ST_EXT: begin
                    int_run_q <= 1'b0;
                    if (leave_req) begin
                        int_run_q <= 1'b1;
                        state_q <= OCC_ST_RETURN;
                    end
                end
                // Back to internal when both clocks low
                OCC_ST_RETURN: begin
                    if (!int_clk && !full_q) begin
                        sel_ext_q <= 1'b0;
                        engaged_q <= 1'b0;
                        state_q <= OCC_ST_INT;
                    end
                end
                default: begin
                    state_q <= OCC_ST_INT;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////
    // Clock outputs
    ////////////////////////////////////////////////////////////

    // Full rate follows the selected source
    assign full_d = sel_ext_q ? ext_lvl : int_clk;

    // Full and half rate; the unit halves again
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            full_q <= 1'b0;
            half_q <= 1'b0;
        end else begin
            full_q <= full_d;
            if (full_d && !full_q) begin
                half_q <= !half_q;
            end
        end
    end

    // No wait-mode input: outputs never change for it
    assign full_rate_clock_o = full_q;
    assign half_rate_clock_o = half_q;
    assign internal_osc_run_o = int_run_q;

    ////////////////////////////////////////////////////////////
    // Pin control
    ////////////////////////////////////////////////////////////

    // Input pin and output pin by mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_en_q <= 1'b0;
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            in_en_q <= ctrl_q.source_select != occ_pkg::OCC_SRC_INT;
            case (ctrl_q.source_select)
                // Amplifier output, enable bit ignored
                occ_pkg::OCC_SRC_XTAL: begin
                    oe_q <= 1'b1;
                    out_q <= !clock_in_pin_i;
                end
                // Pin released to other functions
                occ_pkg::OCC_SRC_EXT: begin
                    oe_q <= 1'b0;
                    out_q <= 1'b0;
                end
                // Internal or RC: optional full-rate out
                default: begin
                    oe_q <= ctrl_q.clock_out_pin_enable;
                    out_q <= ctrl_q.clock_out_pin_enable && full_d;
                end
            endcase
        end
    end

    // No interrupt output; engaged is the only status flag
    assign clock_in_pin_en_o = in_en_q;
    assign clock_out_pin_o = out_q;
    assign clock_out_pin_oe_o = oe_q;

    ////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Engage step then internal stop
    sequence s_engage;
        $rose(engaged_q) && int_run_q;
    endsequence

    // Software asks to leave while engaged
    sequence s_leave;
        state_q == OCC_ST_EXT && leave_req;
    endsequence

    a_reset_low_freq: assert property (
        $fell(rst_i) |-> ctrl_q.internal_freq_select
            == occ_pkg::OCC_FREQ_4M0 && !engaged_q && !sel_ext_q)
        else $error("reset state not internal lowest");

    a_two_edges_seen: assert property (
        $rose(engaged_q) |-> $past(edge_cnt_q, 2) == 2'h2)
        else $error("engaged without two edges");

    a_engage_order: assert property (
        s_engage |=> !int_run_q && engaged_q)
        else $error("internal not stopped after engage");

    a_return_bound: assert property (
        s_leave |-> ##[1:200] !engaged_q)
        else $error("return to internal too slow");

    a_return_clear: assert property (
        $fell(engaged_q) |-> !sel_ext_q && int_run_q)
        else $error("engaged cleared before return");

    a_ext_outen_clr: assert property (
        ctrl_q.source_select == occ_pkg::OCC_SRC_EXT
            |-> !ctrl_q.clock_out_pin_enable ##1 !oe_q)
        else $error("output enable not forced clear");

    a_xtal_pin_own: assert property (
        $stable(ctrl_q.source_select) && ctrl_q.source_select
            == occ_pkg::OCC_SRC_XTAL |=> oe_q && out_q != $past(clock_in_pin_i))
        else $error("crystal pin not amplifier");

    a_clkout_follow: assert property (
        ctrl_q.source_select == occ_pkg::OCC_SRC_INT
            && ctrl_q.clock_out_pin_enable |=> oe_q && out_q == full_q)
        else $error("clock out not full rate");

    a_half_toggle: assert property (
        $rose(full_q) |-> half_q != $past(half_q))
        else $error("half rate missed a toggle");

    a_in_pin_en: assert property (
        ctrl_q.source_select != occ_pkg::OCC_SRC_INT |=> in_en_q)
        else $error("input pin not enabled");

endmodule : occ_top

`default_nettype wire

// ### occ_siu_model.sv
// Integration-unit stand-in: stop gating and clock edge counters
`default_nettype none
module occ_siu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stop_i,
    input wire logic full_rate_clock_i,
    input wire logic half_rate_clock_i,
    output logic stop_source_enable_o,
    output logic [15:0] full_cnt_o,
    output logic [15:0] half_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic full_q; // Last full-rate level
    logic half_q; // Last half-rate level
    // Low while in stop, so sources halt unless kept running
    assign stop_source_enable_o = ~stop_i;
    // Count rising edges, as the bus divider would see them
    always_ff @(posedge clk_i) begin
        full_q <= full_rate_clock_i;
        half_q <= half_rate_clock_i;
        if (rst_i) begin
            full_cnt_o <= 16'h0000;
            half_cnt_o <= 16'h0000;
        end else begin
            full_cnt_o <= full_cnt_o + 16'(full_rate_clock_i & ~full_q);
            half_cnt_o <= half_cnt_o + 16'(half_rate_clock_i & ~half_q);
        end
    end
endmodule // occ_siu_model
`default_nettype wire

// ### tb_top.sv
// Scenario testbench for the oscillator clock switch
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, stop = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, rdat, dat_o;
    logic ack, full, half, in_en, out_pin, oe, run, sen;
    logic [7:0] src_cnt = 8'h00; // Divider for external sources
    logic [15:0] fc, hc;
    int n_mismatch = 0, n_compared = 0, cyc_n = 0;
    occ_top u_occ_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .clock_in_pin_i(src_cnt[1]), .resistor_cap_clock_i(src_cnt[2]),
        .crystal_clock_i(src_cnt[3]), .stop_source_enable_i(sen), .full_rate_clock_o(full),
        .half_rate_clock_o(half), .clock_in_pin_en_o(in_en), .clock_out_pin_o(out_pin),
        .clock_out_pin_oe_o(oe), .internal_osc_run_o(run));
    occ_siu_model u_occ_siu_model (.clk_i(clk_i), .rst_i(rst_i), .stop_i(stop),
        .full_rate_clock_i(full), .half_rate_clock_i(half), .stop_source_enable_o(sen),
        .full_cnt_o(fc), .half_cnt_o(hc));
    // Clock, external sources of period 4, 8 and 16 cycles, hang guard
    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        src_cnt <= src_cnt + 8'h01;
        cyc_n++;
        if (cyc_n == 40000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 0;
        stb <= 0;
    endtask
    // Full edges over 2000 cycles must lie in [lo, hi], half edges within one of half that
    task automatic meas(input int lo, input int hi);
        logic [15:0] f0, h0, df, dh;
        f0 = fc;
        h0 = hc;
        repeat (2000) @(posedge clk_i);
        df = fc - f0;
        dh = hc - h0;
        chk(32'(df >= lo && df <= hi), 32'h1);
        chk(32'(dh + 1 >= df / 2 && dh <= df / 2 + 1), 32'h1);
    endtask
    // Poll the engaged bit until it reaches the wanted level
    task automatic wait_eng(input logic want);
        for (int i = 0; i < 40; i++) begin
            wb(0, 4'h0, 0);
            if (rdat[7] === want) break;
        end
        chk(32'(rdat[7]), 32'(want));
    endtask
    task automatic go_ext(input logic [31:0] c, input int lo, input int hi, input logic eo);
        wb(1, 4'h0, c);
        repeat (3) @(posedge clk_i);
        chk(32'(in_en), 32'h1);
        wb(1, 4'h0, c | 32'h0000_0040);
        wait_eng(1);
        repeat (3) @(posedge clk_i);
        chk(32'(run), 32'h0);
        chk(32'(oe), 32'(eo));
        meas(lo, hi);
        wb(1, 4'h0, 0);
        wait_eng(0);
        repeat (3) @(posedge clk_i);
        chk(32'(run), 32'h1);
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 0;
        wb(0, 4'h0, 0);
        chk(rdat, 0);
        wb(0, 4'h4, 0);
        chk(rdat, 0);
        wb(0, 4'h8, 0);
        chk(rdat, 0);
        chk(32'(run), 32'h1);
        meas(62, 66);
        wb(1, 4'h0, 32'h0000_0004);
        meas(126, 130);
        wb(1, 4'h0, 32'h0000_0008);
        meas(203, 207);
        wb(1, 4'h0, 32'h0000_000C);
        meas(407, 412);
        wb(1, 4'h4, 32'h0000_007F);
        meas(300, 395);
        wb(1, 4'h4, 32'h0000_0080);
        meas(420, 600);
        wb(0, 4'h4, 0);
        chk(rdat, 32'h0000_0080);
        wb(1, 4'h4, 0);
        wb(1, 4'h0, 32'h0000_0100);
        repeat (4) @(posedge clk_i);
        chk(32'(oe), 32'h1);
        // Pin must carry the full-rate clock level while enabled
        repeat (5) begin
            @(posedge clk_i);
            chk(32'(out_pin), 32'(full));
        end
        wb(1, 4'h0, 32'h0000_0101);
        wb(0, 4'h0, 0);
        chk(32'(rdat[8]), 32'h0);
        go_ext(32'h0000_0001, 498, 502, 0);
        go_ext(32'h0000_0102, 248, 252, 1);
        go_ext(32'h0000_0013, 123, 127, 1);
        wb(1, 4'h0, 32'h0000_000C);
        stop <= 1;
        repeat (20) @(posedge clk_i);
        meas(0, 1);
        wb(1, 4'h0, 32'h0000_020C);
        meas(407, 412);
        stop <= 0;
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
